// [core/line_test_pattern.sv]
// Purpose: Test pattern generator and detector for one line channel
// Assumes: All line clocks and data arrive as pins and are oversampled
// Notes:   Line clocks must stay well below a quarter of CLK
// Notes on behaviour
// - Receive generation clock: reference or recovered
// - Transmit generation clock: reference, pin or rails
// - Enable field picks off, PRBS, user, inband
// - Direction bit routes generator to transmit/receive
// - Invert bit flips generated PRBS and user bits
// - Polynomial select picks QRSS, 15 or 11
// - Detect direction picks receive or transmit stream
// - Detect invert flips data before comparison
// - Detect select picks expected PRBS or user
// - 24-bit user pattern, bit 23 first, repeating
// - Generation code length five to eight bits
// - Activate code length five to eight bits
// - Deactivate code length five to eight bits
// - Inband code sent MSB first, repeated continuously
// - Activate code matched, bit zero last
// - Deactivate code matched, bit zero last
// - Insert bit rising flips one PRBS or user bit, self-clears
// - Source 111 counts pattern detector mismatches
// - Auto loopback after code held 5.1 s
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module line_test_pattern
  import line_test_pkg::*;
#(
  parameter longint LOOP_HOLD = LOOP_HOLD_CYCLES
)
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        TX_RZ_FORMAT,
  input  wire logic        REF_CLK_IN,
  input  wire logic        RX_RECOVERED_CLK,
  input  wire logic        RX_DATA,
  input  wire logic        TX_CLK_PIN,
  input  wire logic        TX_POS_RAIL,
  input  wire logic        TX_NEG_RAIL,
  output logic             GEN_TX_BIT,
  output logic             GEN_TX_ACTIVE,
  output logic             GEN_RX_BIT,
  output logic             GEN_RX_ACTIVE,
  output logic             PATTERN_ERROR,
  output logic             ACTIVATE_DETECT,
  output logic             DEACTIVATE_DETECT,
  output logic             DIGITAL_LOOP,
  output logic             REMOTE_LOOP
);

  typedef struct packed {
    logic [7:0]  gen_ctrl;
    logic [7:0]  det_ctrl;
    logic [23:0] user_pattern_bits;
    logic [7:0]  code_len;
    logic [7:0]  gen_code_bits;
    logic [7:0]  activate_code_bits;
    logic [7:0]  deactivate_code_bits;
    logic [7:0]  aux_ctrl;
    logic [15:0] err_cnt;
    pin_sync_s   pins;
    logic        err_pend;
    logic [19:0] gen_lfsr;
    logic [4:0]  gen_ph;
    det_state_e  det_state;
    logic [19:0] det_hist;
    logic [4:0]  det_ph;
    logic [5:0]  det_run;
    logic [7:0]  ib_hist;
    logic        act_on;
    logic        deact_on;
    logic [29:0] act_tmr;
    logic [29:0] deact_tmr;
    logic        dig_loop;
    logic        rem_loop;
    logic        gen_tx_bit;
    logic        gen_tx_act;
    logic        gen_rx_bit;
    logic        gen_rx_act;
    logic        pat_err;
    ahb_slave_s  ahb;
  } state_s;

  localparam logic [29:0] HOLD = 30'(LOOP_HOLD);

  state_s q;
  state_s d;

  // Feedback of the selected LFSR; an all-zero window is kicked out
  function automatic logic lfsr_fb(input logic [19:0] s,
                                   input logic [1:0]  sel);
    logic fb;
    fb = 1'b0;
    case (sel)
      2'b00:   fb = (s == 20'h00000) | (s[19] ^ s[16]);
      2'b01:   fb = (s[14:0] == 15'h0000) | (s[14] ^ s[13]);
      default: fb = (s[10:0] == 11'h000) | (s[10] ^ s[8]);
    endcase
    return fb;
  endfunction : lfsr_fb

  // Mask of the valid low-order code bits for a length field
  function automatic logic [7:0] code_mask(input logic [1:0] len);
    return 8'hFF >> (2'd3 - len);
  endfunction : code_mask

  // Inband presence tracker
  function automatic logic ib_track(input logic       on,
                                    input logic [7:0] hist,
                                    input logic [7:0] code,
                                    input logic [1:0] len,
                                    input logic       bit_in);
    logic [7:0] win;
    logic       hit;
    logic       same;
    win  = {hist[6:0], bit_in};
    hit  = ((win ^ code) & code_mask(len)) == 8'h00;
    same = bit_in == hist[3'(3'd4 + {1'b0, len})];
    return hit | (on & same);
  endfunction : ib_track

  logic [1:0] gen_mode;
  logic [1:0] gen_poly;
  logic [1:0] det_sel;
  logic [2:0] gen_last;
  logic       rz_lvl;
  logic       rz_next;
  logic       rz_tick;
  logic [5:0] rise;
  logic       gen_tick;
  logic       det_tick;
  logic       mon_bit;
  logic       cmp_bit;
  logic       exp_bit;
  logic       gbit;
  logic       ins;
  logic       accept;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  always_comb
  begin
    d        = q;
    gen_mode = q.gen_ctrl[GEN_EN_LSB +: 2];
    gen_poly = q.gen_ctrl[GEN_POLY_LSB +: 2];
    det_sel  = q.det_ctrl[DET_SEL_LSB +: 2];
    gen_last = 3'd4 + {1'b0, q.code_len[GEN_LEN_LSB +: 2]};
    gbit     = 1'b0;
    exp_bit  = 1'b0;
    ins      = 1'b0;
    wbyte    = HWDATA[7:0];
    rbyte    = 8'h00;

    // Pin sampling: first stage feeds only the second
    d.pins.s1   = {TX_NEG_RAIL, TX_POS_RAIL, TX_CLK_PIN,
                   RX_DATA, RX_RECOVERED_CLK, REF_CLK_IN};
    d.pins.s2   = q.pins.s1;
    d.pins.s3   = q.pins.s2;
    d.pins.filt = (q.pins.s2 & q.pins.s3) |
                  (q.pins.filt & (q.pins.s2 | q.pins.s3));
    rise    = d.pins.filt & ~q.pins.filt;
    rz_lvl  = q.pins.filt[PIN_POS] | q.pins.filt[PIN_NEG];
    rz_next = d.pins.filt[PIN_POS] | d.pins.filt[PIN_NEG];
    rz_tick = rz_next & ~rz_lvl;

    // Generator clock choice
    if (!q.gen_ctrl[GEN_CLK_SEL_BIT])
      gen_tick = rise[PIN_REF];
    else if (q.gen_ctrl[GEN_DIR_BIT])
      gen_tick = rise[PIN_RXCK];
    else
      gen_tick = TX_RZ_FORMAT ? rz_tick : rise[PIN_TXCK];

    // Detector clock and monitored stream
    if (q.det_ctrl[DET_DIR_BIT])
    begin
      det_tick = TX_RZ_FORMAT ? rz_tick : rise[PIN_TXCK];
      mon_bit  = TX_RZ_FORMAT ? rz_lvl : q.pins.filt[PIN_POS];
    end
    else
    begin
      det_tick = rise[PIN_RXCK];
      mon_bit  = q.pins.filt[PIN_RXD];
    end
    cmp_bit = mon_bit ^ q.det_ctrl[DET_INV_BIT];

    // Generator
    d.gen_tx_act = (gen_mode != GEN_OFF) & ~q.gen_ctrl[GEN_DIR_BIT];
    d.gen_rx_act = (gen_mode != GEN_OFF) & q.gen_ctrl[GEN_DIR_BIT];
    if (gen_tick)
    begin
      case (gen_mode)
        GEN_PRBS:
        begin
          gbit       = lfsr_fb(q.gen_lfsr, gen_poly);
          d.gen_lfsr = {q.gen_lfsr[18:0], gbit};
          ins        = q.err_pend;
          gbit       = gbit ^ q.gen_ctrl[GEN_INV_BIT] ^ ins;
        end
        GEN_USER:
        begin
          gbit     = q.user_pattern_bits[5'd23 - q.gen_ph];
          d.gen_ph = (q.gen_ph == USER_LAST_PH) ? 5'd0 : q.gen_ph + 5'd1;
          ins      = q.err_pend;
          gbit     = gbit ^ q.gen_ctrl[GEN_INV_BIT] ^ ins;
        end
        GEN_INBAND:
        begin
          // Valid low bits, MSB first, bit 0 last, then repeat
          gbit     = q.gen_code_bits[gen_last - q.gen_ph[2:0]];
          d.gen_ph = (q.gen_ph[2:0] >= gen_last) ? 5'd0
                                                 : q.gen_ph + 5'd1;
        end
        default:
          d.gen_ph = 5'd0;
      endcase
      if (q.gen_ctrl[GEN_DIR_BIT])
        d.gen_rx_bit = gbit;
      else
        d.gen_tx_bit = gbit;
    end

    // Single error insertion completes and clears its control bit
    if (ins)
    begin
      d.err_pend                 = 1'b0;
      d.aux_ctrl[ERR_INSERT_BIT] = 1'b0;
    end

    // Pattern detector
    d.pat_err = 1'b0;
    if (det_tick)
    begin
      if (det_sel == DET_USER)
        exp_bit = q.user_pattern_bits[5'd23 - q.det_ph];
      else
        exp_bit = lfsr_fb(q.det_hist, det_sel);
      case (q.det_state)
        DET_HUNT:
        begin
          // Seed from the line so the local sequence follows it
          d.det_hist = {q.det_hist[18:0], cmp_bit};
          if (cmp_bit == exp_bit)
          begin
            d.det_run = q.det_run + 6'd1;
            d.det_ph  = (q.det_ph == USER_LAST_PH) ? 5'd0
                                                   : q.det_ph + 5'd1;
            if (q.det_run + 6'd1 >= LOCK_MATCHES)
            begin
              d.det_state = DET_LOCK;
              d.det_run   = 6'd0;
            end
          end
          else
            d.det_run = 6'd0; // Holding the phase slips one bit
        end
        DET_LOCK:
        begin
          // Free-running once locked, so one line error costs one count
          d.det_hist = {q.det_hist[18:0], exp_bit};
          d.det_ph   = (q.det_ph == USER_LAST_PH) ? 5'd0
                                                  : q.det_ph + 5'd1;
          if (cmp_bit != exp_bit)
          begin
            d.pat_err = 1'b1;
            d.det_run = q.det_run + 6'd1;
            if (q.det_run + 6'd1 >= LOSS_ERRORS)
            begin
              d.det_state = DET_HUNT;
              d.det_run   = 6'd0;
            end
          end
          else
            d.det_run = 6'd0;
        end
        default:
          d.det_state = DET_HUNT;
      endcase

      // Inband code detection on the uninverted stream
      d.ib_hist  = {q.ib_hist[6:0], mon_bit};
      d.act_on   = ib_track(q.act_on, q.ib_hist, q.activate_code_bits,
                            q.code_len[ACT_LEN_LSB +: 2],
                            mon_bit);
      d.deact_on = ib_track(q.deact_on, q.ib_hist, q.deactivate_code_bits,
                            q.code_len[DEACT_LEN_LSB +: 2],
                            mon_bit);
    end

    // Automatic loopback timers
    if (q.aux_ctrl[AUTO_LOOP_BIT])
    begin
      d.act_tmr   = !q.act_on ? 30'd0
                  : (q.act_tmr > HOLD) ? q.act_tmr : q.act_tmr + 30'd1;
      d.deact_tmr = !q.deact_on ? 30'd0
                  : (q.deact_tmr > HOLD) ? q.deact_tmr
                                         : q.deact_tmr + 30'd1;
      if (q.act_tmr > HOLD)
      begin
        if (q.det_ctrl[DET_DIR_BIT])
          d.dig_loop = 1'b1;
        else
          d.rem_loop = 1'b1;
      end
      if (q.deact_tmr > HOLD)
      begin
        d.dig_loop = 1'b0;
        d.rem_loop = 1'b0;
      end
    end
    else
    begin
      d.act_tmr   = 30'd0;
      d.deact_tmr = 30'd0;
      d.dig_loop  = 1'b0;
      d.rem_loop  = 1'b0;
    end

    // Error counter: a clearing write zeroes it, then a same-cycle error counts one
    if (q.ahb.wr && q.ahb.idx == IDX_ERR_COUNT)
      d.err_cnt = 16'h0000;
    if (q.pat_err && q.aux_ctrl[ERR_SRC_LSB +: 3] == ERR_SRC_PAT &&
        d.err_cnt != 16'hFFFF)
      d.err_cnt = d.err_cnt + 16'h0001;

    // Register writes in the data phase
    if (q.ahb.wr)
    begin
      case (q.ahb.idx)
        IDX_GEN_CTRL:   d.gen_ctrl                    = wbyte & 8'h7F;
        IDX_DET_CTRL:   d.det_ctrl                    = wbyte & 8'h0F;
        IDX_PAT_LOW:    d.user_pattern_bits[7:0]      = wbyte;
        IDX_PAT_MID:    d.user_pattern_bits[15:8]     = wbyte;
        IDX_PAT_HIGH:   d.user_pattern_bits[23:16]    = wbyte;
        IDX_CODE_LEN:   d.code_len                    = wbyte & 8'h3F;
        IDX_GEN_CODE:   d.gen_code_bits               = wbyte;
        IDX_ACT_CODE:   d.activate_code_bits          = wbyte;
        IDX_DEACT_CODE: d.deactivate_code_bits        = wbyte;
        IDX_AUX_CTRL:
        begin
          d.aux_ctrl = wbyte & 8'h1F;
          if (wbyte[ERR_INSERT_BIT] && (!q.aux_ctrl[ERR_INSERT_BIT] || ins))
            d.err_pend = 1'b1;
        end
        default: ;
      endcase
    end

    // Read mux for the wait-stated data phase
    case (q.ahb.idx)
      IDX_GEN_CTRL:   rbyte = q.gen_ctrl;
      IDX_DET_CTRL:   rbyte = q.det_ctrl;
      IDX_PAT_LOW:    rbyte = q.user_pattern_bits[7:0];
      IDX_PAT_MID:    rbyte = q.user_pattern_bits[15:8];
      IDX_PAT_HIGH:   rbyte = q.user_pattern_bits[23:16];
      IDX_CODE_LEN:   rbyte = q.code_len;
      IDX_GEN_CODE:   rbyte = q.gen_code_bits;
      IDX_ACT_CODE:   rbyte = q.activate_code_bits;
      IDX_DEACT_CODE: rbyte = q.deactivate_code_bits;
      IDX_AUX_CTRL:   rbyte = q.aux_ctrl;
      IDX_STATUS:     rbyte = {3'b000, q.rem_loop, q.dig_loop,
                               q.det_state == DET_LOCK,
                               q.deact_on, q.act_on};
      default:        rbyte = 8'h00;
    endcase

    // AHB-Lite slave: writes take no wait, reads take one
    accept   = HSEL & HTRANS[1] & HREADY;
    d.ahb.wr = accept & HWRITE;
    d.ahb.rd = accept & ~HWRITE;
    if (accept)
      d.ahb.idx = HADDR[11:2];
    if (q.ahb.rd)
    begin
      d.ahb.rdata = (q.ahb.idx == IDX_ERR_COUNT) ? {16'h0000, q.err_cnt}
                                                 : {24'h000000, rbyte};
      d.ahb.ready = 1'b1;
    end
    else if (accept & ~HWRITE)
      d.ahb.ready = 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      q                      <= '0;
      q.gen_ctrl             <= RST_GEN_CTRL;
      q.det_ctrl             <= RST_DET_CTRL;
      q.user_pattern_bits    <= {RST_PAT_BYTE, RST_PAT_BYTE, RST_PAT_BYTE};
      q.code_len             <= RST_CODE_LEN;
      q.gen_code_bits        <= RST_GEN_CODE;
      q.activate_code_bits   <= RST_ACT_CODE;
      q.deactivate_code_bits <= RST_DEACT_CODE;
      q.aux_ctrl             <= RST_AUX_CTRL;
      q.gen_lfsr             <= RST_LFSR;
      q.det_state            <= DET_HUNT;
      q.ahb.ready            <= 1'b1;
    end
    else if (CE)
      q <= d;
  end

  assign HRDATA            = q.ahb.rdata;
  assign HREADYOUT         = q.ahb.ready;
  assign HRESP             = 1'b0;
  assign GEN_TX_BIT        = q.gen_tx_bit;
  assign GEN_TX_ACTIVE     = q.gen_tx_act;
  assign GEN_RX_BIT        = q.gen_rx_bit;
  assign GEN_RX_ACTIVE     = q.gen_rx_act;
  assign PATTERN_ERROR     = q.pat_err;
  assign ACTIVATE_DETECT   = q.act_on;
  assign DEACTIVATE_DETECT = q.deact_on;
  assign DIGITAL_LOOP      = q.dig_loop;
  assign REMOTE_LOOP       = q.rem_loop;

endmodule : line_test_pattern

`default_nettype wire

// [core/line_test_pkg.sv]
// Purpose: Constants and types for the line test pattern unit
// Assumes: One channel, 125 MHz system clock, AHB-Lite register access
// Notes:   Register indices map to byte address index * 4
package line_test_pkg;

  // Register indices (byte address = index * 4)
  localparam logic [9:0] IDX_GEN_CTRL    = 10'h010;
  localparam logic [9:0] IDX_DET_CTRL    = 10'h011;
  localparam logic [9:0] IDX_PAT_LOW     = 10'h012;
  localparam logic [9:0] IDX_PAT_MID     = 10'h013;
  localparam logic [9:0] IDX_PAT_HIGH    = 10'h014;
  localparam logic [9:0] IDX_CODE_LEN    = 10'h015;
  localparam logic [9:0] IDX_GEN_CODE    = 10'h016;
  localparam logic [9:0] IDX_ACT_CODE    = 10'h017;
  localparam logic [9:0] IDX_DEACT_CODE  = 10'h018;
  localparam logic [9:0] IDX_AUX_CTRL    = 10'h01C;
  localparam logic [9:0] IDX_ERR_COUNT   = 10'h01D;
  localparam logic [9:0] IDX_STATUS      = 10'h01E;

  // Reset values
  localparam logic [7:0] RST_GEN_CTRL    = 8'h00;
  localparam logic [7:0] RST_DET_CTRL    = 8'h03;
  localparam logic [7:0] RST_PAT_BYTE    = 8'h55;
  localparam logic [7:0] RST_CODE_LEN    = 8'h01;
  localparam logic [7:0] RST_GEN_CODE    = 8'h01;
  localparam logic [7:0] RST_ACT_CODE    = 8'h01;
  localparam logic [7:0] RST_DEACT_CODE  = 8'h09;
  localparam logic [7:0] RST_AUX_CTRL    = 8'h00;
  localparam logic [19:0] RST_LFSR       = 20'hFFFFF;

  // Field positions
  localparam int GEN_CLK_SEL_BIT   = 6;
  localparam int GEN_EN_LSB        = 4;
  localparam int GEN_DIR_BIT       = 3;
  localparam int GEN_INV_BIT       = 2;
  localparam int GEN_POLY_LSB      = 0;
  localparam int DET_DIR_BIT       = 3;
  localparam int DET_INV_BIT       = 2;
  localparam int DET_SEL_LSB       = 0;
  localparam int GEN_LEN_LSB       = 4;
  localparam int ACT_LEN_LSB       = 2;
  localparam int DEACT_LEN_LSB     = 0;
  localparam int AUTO_LOOP_BIT     = 0;
  localparam int ERR_INSERT_BIT    = 1;
  localparam int ERR_SRC_LSB       = 2;

  // Field encodings
  localparam logic [1:0] GEN_OFF       = 2'b00;
  localparam logic [1:0] GEN_PRBS      = 2'b01;
  localparam logic [1:0] GEN_USER      = 2'b10;
  localparam logic [1:0] GEN_INBAND    = 2'b11;
  localparam logic [1:0] DET_USER      = 2'b11;
  localparam logic [2:0] ERR_SRC_PAT   = 3'b111;
  localparam logic [4:0] USER_LAST_PH  = 5'd23;

  // Detector lock and loss thresholds, in monitored bits
  localparam logic [5:0] LOCK_MATCHES  = 6'd32;
  localparam logic [5:0] LOSS_ERRORS   = 6'd8;

  // Loopback hold time
  localparam longint CLK_HZ            = 125_000_000;
  localparam longint LOOP_HOLD_MS      = 5100;
  localparam longint LOOP_HOLD_CYCLES  = LOOP_HOLD_MS * (CLK_HZ / 1000);

  // Sampled pin slots
  localparam int PIN_REF   = 0;
  localparam int PIN_RXCK  = 1;
  localparam int PIN_RXD   = 2;
  localparam int PIN_TXCK  = 3;
  localparam int PIN_POS   = 4;
  localparam int PIN_NEG   = 5;

  typedef enum logic {DET_HUNT, DET_LOCK} det_state_e;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] filt;
  } pin_sync_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [9:0]  idx;
    logic [31:0] rdata;
    logic        ready;
  } ahb_slave_s;

endpackage : line_test_pkg

// [verification/line_test_monitor.sv]
// Purpose: Port checks for the line test pattern unit
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the top module after the endmodule
`timescale 1ns/1ps
`default_nettype none

module line_test_monitor
#(
  parameter longint LOOP_HOLD = 50
)
(
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        CE,
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        GEN_TX_ACTIVE,
  input wire logic        GEN_RX_ACTIVE,
  input wire logic        PATTERN_ERROR,
  input wire logic        ACTIVATE_DETECT,
  input wire logic        DIGITAL_LOOP,
  input wire logic        REMOTE_LOOP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  logic   taken;
  longint act_q;

  assign taken = HSEL && HTRANS[1] && HREADY && CE;

  // Margin of two for output latency
  always_ff @(posedge CLK)
  begin
    if (!RESET_N || !ACTIVATE_DETECT)
      act_q <= 0;
    else
      act_q <= act_q + 1;
  end

  sequence read_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence

  chk_resp_okay:
    assert property (!HRESP) else $error("HRESP not OKAY");
  chk_read_wait:
    assert property (taken && !HWRITE |=> read_wait)
    else $error("Read not one wait state");
  chk_write_nowait:
    assert property (taken && HWRITE |=> HREADYOUT)
    else $error("Write stalled");
  chk_rdata_hold:
    assert property ($changed(HRDATA) |-> $rose(HREADYOUT))
    else $error("HRDATA moved outside a read");
  chk_gen_one_path:
    assert property (!(GEN_TX_ACTIVE && GEN_RX_ACTIVE))
    else $error("Generator on both paths");
  chk_loop_single:
    assert property (!(DIGITAL_LOOP && REMOTE_LOOP))
    else $error("Both loops on");
  chk_loop_hold:
    assert property ($rose(DIGITAL_LOOP || REMOTE_LOOP)
                     |-> act_q >= LOOP_HOLD - 2)
    else $error("Loop entered early");
  chk_error_pulse:
    assert property (PATTERN_ERROR |=> !PATTERN_ERROR)
    else $error("Error pulse too long");
endmodule : line_test_monitor

bind line_test_pattern line_test_monitor #(.LOOP_HOLD(LOOP_HOLD)) mon (
  .CLK(CLK), .RESET_N(RESET_N), .CE(CE), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .GEN_TX_ACTIVE(GEN_TX_ACTIVE),
  .GEN_RX_ACTIVE(GEN_RX_ACTIVE), .PATTERN_ERROR(PATTERN_ERROR),
  .ACTIVATE_DETECT(ACTIVATE_DETECT), .DIGITAL_LOOP(DIGITAL_LOOP),
  .REMOTE_LOOP(REMOTE_LOOP)
);
`default_nettype wire

// [verification/line_partner.sv]
// Purpose: Line side model: reference, line clocks and code data
// Assumes: Clocks far below a quarter of the system clock
// Notes:   The path not chosen carries the inverse stream
`timescale 1ns/1ps
`default_nettype none

module line_partner
(
  input  wire logic       clk,
  input  wire logic [7:0] code,
  input  wire logic [3:0] len,
  input  wire logic       path,
  output logic            ref_ck,
  output logic            line_ck,
  output logic            tx_ck,
  output logic            rx_d,
  output logic            tx_pos,
  output logic            tx_neg
);
  int rc = 0;
  int lc = 0;
  int ph = 0;

  initial
  begin
    ref_ck = 1'b0;
    line_ck = 1'b0;
  end

  // Data moves mid-phase, clear of both edges
  always @(posedge clk)
  begin
    rc <= (rc == 5) ? 0 : rc + 1;
    lc <= (lc == 19) ? 0 : lc + 1;
    if (rc == 5)
      ref_ck <= ~ref_ck;
    if (lc == 0)
      line_ck <= 1'b1;
    if (lc == 10)
      line_ck <= 1'b0;
    if (lc == 5)
      ph <= (ph == 0) ? int'(len) - 1 : ph - 1;
  end

  assign tx_ck = ~line_ck;
  assign rx_d = path ? ~code[ph] : code[ph];
  assign tx_pos = path ? code[ph] : ~code[ph];
  assign tx_neg = 1'b0;
endmodule : line_partner
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the line test pattern unit
// Assumes: Partner makes line clocks, bench is the bus master
// Notes:   Short loop hold keeps the run brief
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import line_test_pkg::*;

  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  pcode = 8'h01;
  logic [3:0]  plen = 4'h5;
  logic        ppath = 1'b0;
  logic [31:0] rd;
  int          err_count = 0;
  int          total_checks = 0;
  wire  [31:0] hrdata;
  wire         hready, ref_ck, line_ck, tx_ck, rx_d, tx_pos, tx_neg;
  wire         gen_tx, gen_rx;
  wire  [3:0]  flags;

  line_test_pattern #(.LOOP_HOLD(50)) uut (
    .CLK(clk), .RESET_N(reset_n), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(),
    .TX_RZ_FORMAT(1'b0), .REF_CLK_IN(ref_ck), .RX_RECOVERED_CLK(line_ck),
    .RX_DATA(rx_d), .TX_CLK_PIN(tx_ck), .TX_POS_RAIL(tx_pos),
    .TX_NEG_RAIL(tx_neg), .GEN_TX_BIT(gen_tx), .GEN_TX_ACTIVE(),
    .GEN_RX_BIT(gen_rx), .GEN_RX_ACTIVE(), .PATTERN_ERROR(),
    .ACTIVATE_DETECT(flags[0]), .DEACTIVATE_DETECT(flags[1]),
    .DIGITAL_LOOP(flags[2]), .REMOTE_LOOP(flags[3]));

  line_partner lp (.clk(clk), .code(pcode), .len(plen), .path(ppath),
    .ref_ck(ref_ck), .line_ck(line_ck), .tx_ck(tx_ck), .rx_d(rx_d),
    .tx_pos(tx_pos), .tx_neg(tx_neg));

  always #4 clk = ~clk;

  task automatic print_verdict;
    $display("Checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // hready is stable by the falling edge
  task automatic bus_wait;
    int n;
    n = 0;
    @(negedge clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 100)
      begin
        err_count++;
        print_verdict();
      end
      @(negedge clk);
    end
    rd = hrdata;
    @(posedge clk);
  endtask : bus_wait

  task automatic xfer(input logic w, input logic [9:0] idx,
                      input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, idx, 2'b00};
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    bus_wait();
  endtask : xfer

  task automatic grab(input logic [7:0] c, output logic [47:0] s);
    xfer(1'b1, IDX_GEN_CTRL, c);
    repeat (300) @(posedge clk);
    for (int i = 0; i < 48; i++)
    begin
      if (!c[GEN_CLK_SEL_BIT])
        @(posedge ref_ck);
      else if (c[GEN_DIR_BIT])
        @(posedge line_ck);
      else
        @(posedge tx_ck);
      repeat (6) @(negedge clk);
      s[i] = c[GEN_DIR_BIT] ? gen_rx : gen_tx;
    end
    @(posedge clk);
  endtask : grab

  task automatic rot_check(input string nm, input logic [47:0] s,
                           input logic [23:0] p, input int len);
    int hit;
    int bad;
    hit = 0;
    for (int k = 0; k < len; k++)
    begin
      bad = 0;
      for (int i = 0; i < 48; i++)
        if (s[i] !== p[len - 1 - (k + i) % len])
          bad++;
      if (bad == 0)
        hit = 1;
    end
    check(nm, 32'h1, hit);
  endtask : rot_check

  task automatic prbs_check(input logic [47:0] s, input int a, b,
                            input logic inv);
    int v;
    v = 0;
    for (int i = a; i < 48; i++)
      if ((s[i] ^ s[i - a] ^ s[i - b]) !== inv)
        v++;
    check("prbs recurrence", 32'h0, v);
  endtask : prbs_check

  task automatic wait_flags(input logic [3:0] v);
    int n;
    n = 0;
    while (flags !== v && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    check("detect flags", {28'h0, v}, {28'h0, flags});
    if (flags !== v)
      print_verdict();
    @(posedge clk);
  endtask : wait_flags

  task automatic s_reset;
    logic [9:0] ix [10];
    logic [7:0] rv [10];
    ix = '{IDX_GEN_CTRL, IDX_DET_CTRL, IDX_PAT_LOW, IDX_PAT_MID,
           IDX_PAT_HIGH, IDX_CODE_LEN, IDX_GEN_CODE, IDX_ACT_CODE,
           IDX_DEACT_CODE, 10'h030};
    rv = '{8'h00, 8'h03, 8'h55, 8'h55, 8'h55, 8'h01, 8'h01, 8'h01,
           8'h09, 8'h00};
    for (int i = 0; i < 10; i++)
    begin
      xfer(1'b0, ix[i], 8'h00);
      check("reset value", {24'h0, rv[i]}, rd);
    end
  endtask : s_reset

  task automatic s_masks;
    xfer(1'b1, IDX_GEN_CTRL, 8'hFF);
    xfer(1'b1, IDX_DET_CTRL, 8'hFF);
    xfer(1'b1, 10'h030, 8'hFF);
    xfer(1'b0, IDX_GEN_CTRL, 8'h00);
    check("gen control", 32'h7F, rd);
    xfer(1'b0, IDX_DET_CTRL, 8'h00);
    check("detect control", 32'h0F, rd);
    xfer(1'b0, 10'h030, 8'h00);
    check("unmapped", 32'h0, rd);
  endtask : s_masks

  task automatic s_user;
    logic [47:0] s;
    xfer(1'b1, IDX_PAT_HIGH, 8'h6B);
    xfer(1'b1, IDX_PAT_MID, 8'h2C);
    xfer(1'b1, IDX_PAT_LOW, 8'h1F);
    grab(8'h20, s);
    rot_check("user tx ref", s, 24'h6B2C1F, 24);
    grab(8'h24, s);
    rot_check("user inverted", s, 24'h94D3E0, 24);
    grab(8'h28, s);
    rot_check("user rx ref", s, 24'h6B2C1F, 24);
    grab(8'h68, s);
    rot_check("user rx line", s, 24'h6B2C1F, 24);
    grab(8'h60, s);
    rot_check("user tx pin", s, 24'h6B2C1F, 24);
  endtask : s_user

  task automatic s_prbs;
    logic [47:0] s;
    for (int p = 0; p < 4; p++)
    begin
      grab(8'h10 + 8'(p), s);
      prbs_check(s, p == 0 ? 20 : p == 1 ? 15 : 11,
                 p == 0 ? 17 : p == 1 ? 14 : 9, 1'b0);
    end
    grab(8'h17, s);
    prbs_check(s, 11, 9, 1'b1);
  endtask : s_prbs

  // From six bits on, 0x0B is not its mirror rotated
  task automatic s_inband;
    logic [47:0] s;
    xfer(1'b1, IDX_GEN_CODE, 8'h0B);
    for (int l = 0; l < 4; l++)
    begin
      xfer(1'b1, IDX_CODE_LEN, {2'b00, 2'(l), 4'h1});
      grab(8'h30, s);
      rot_check("inband code", s, 24'h00000B, 5 + l);
    end
    xfer(1'b1, IDX_CODE_LEN, 8'h01);
  endtask : s_inband

  task automatic s_loop(input logic d);
    xfer(1'b1, IDX_DET_CTRL, {4'h0, d, 3'b011});
    xfer(1'b1, IDX_AUX_CTRL, 8'h01);
    ppath <= d;
    pcode <= 8'h01;
    plen <= 4'h5;
    wait_flags(d ? 4'b0101 : 4'b1001);
    xfer(1'b0, IDX_STATUS, 8'h00);
    check("status", {27'h0, ~d, d, 3'h1}, rd);
    pcode <= 8'h09;
    plen <= 4'h6;
    wait_flags(4'b0010);
    xfer(1'b1, IDX_AUX_CTRL, 8'h00);
  endtask : s_loop

  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    s_reset();
    s_masks();
    s_user();
    s_prbs();
    s_inband();
    s_loop(1'b0);
    s_loop(1'b1);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
